// file: spi_wiper_position_loader.sv
// Purpose: Serial receive path that loads an 8-bit wiper code on chip-select rise
// Assumes: Link clock well below clk/4; all pins synchronised into clk domain
// Notes: Tap select output is a one-hot decode of the wiper register
// Notes: Pin changes reach the registers three clk edges late
// Notes: Select must stay high at least two clk periods between frames
`timescale 1ns/1ps

// Behaviour
// R1: While select is low, shift data in on each serial clock rise.
// R2: Master sends 8 bits MSB first; first bit lands in bit 7.
// R3: On each select rise, copy the shift register into the wiper register.
// R4: Copy happens on every select rise, even with no new bits.
// R5: Extra bits push out the earliest ones; last eight are kept.
// R6: Reset clears the shift register to zero.
// R7: Reset loads the wiper register with midscale 0x80.
// R8: Wiper stays at midscale while select stays high after reset.
// R9: Select toggle with no bits after reset loads 0x00.
// R10: Wiper code decodes to one of 256 taps; 0x00 is the B end.
// R11: Wiper changes only at the select rise, never while select is low.
module spi_wiper_position_loader #(
    parameter int CODE_W = wiper_pkg::CODE_W,
    parameter int TAPS = wiper_pkg::TAPS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic [CODE_W-1:0] wiper_code,
    output logic [TAPS-1:0] tap_sel
);
    // Synchroniser stages, pin order sclk, cs_n, sdi
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    // Synchronised pin levels
    logic sclk_s;
    logic cs_n_s;
    logic sdi_s;
    // Previous synchronised levels for edge detection
    logic sclk_d_r;
    logic cs_d_r;
    // Single-cycle edge events and the select-low level in the clk domain
    logic sclk_rise;
    logic cs_rise;
    logic cs_low;
    // Serial input register and wiper register
    logic [CODE_W-1:0] shift_r;
    logic [CODE_W-1:0] shift_nxt;
    logic [CODE_W-1:0] wiper_r;
    logic [TAPS-1:0] tap_r;

    // One-hot tap select for a wiper code; code 0 is the B end
    function automatic logic [TAPS-1:0] decode(input logic [CODE_W-1:0] code);
        logic [TAPS-1:0] v;
        v = '0;
        v[code] = 1'b1;
        return v;
    endfunction : decode

    // Two-stage synchronisers for the three pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= wiper_pkg::PIN_IDLE;
            s2_r <= wiper_pkg::PIN_IDLE;
        end else begin
            s1_r <= {sclk, cs_n, sdi};
            s2_r <= s1_r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d_r <= wiper_pkg::PIN_IDLE[wiper_pkg::SCLK_POS];
            cs_d_r <= wiper_pkg::PIN_IDLE[wiper_pkg::CS_POS];
        end else begin
            sclk_d_r <= sclk_s;
            cs_d_r <= cs_n_s;
        end
    end

    // Only the second stage is read by logic
    assign sclk_s = s2_r[wiper_pkg::SCLK_POS];
    assign cs_n_s = s2_r[wiper_pkg::CS_POS];
    assign sdi_s = s2_r[wiper_pkg::SDI_POS];

    // Reset levels are all high, so release gives no false rising edge
    assign sclk_rise = sclk_s && !sclk_d_r;
    assign cs_rise = cs_n_s && !cs_d_r;
    assign cs_low = !cs_n_s;

    // MSB first: shift left so oldest bits fall off the top
    assign shift_nxt = {shift_r[CODE_W-2:0], sdi_s}; // see R2 see R5

    // Serial input register moves only on a link clock rise with select low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift_r <= CODE_W'(wiper_pkg::SHIFT_RESET); // see R6
        end else if (cs_low && sclk_rise) begin
            shift_r <= shift_nxt; // see R1
        end
    end

    // Wiper register loads only on the synchronised select rise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wiper_r <= CODE_W'(wiper_pkg::WIPER_RESET); // see R7 see R8
        end else if (cs_rise) begin
            wiper_r <= shift_r; // see R3 see R4 see R9 see R11
        end
    end

    // Registered decode keeps tap_sel straight from a flop, one clk behind
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tap_r <= decode(CODE_W'(wiper_pkg::WIPER_RESET));
        end else begin
            tap_r <= decode(wiper_r); // see R10
        end
    end

    assign wiper_code = wiper_r;
    assign tap_sel = tap_r;

    property p_shift_in;
        @(posedge clk) disable iff (!rstn)
        (cs_low && sclk_rise) |=> shift_r == $past(shift_nxt);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift missed"); // see R1

    property p_hold_shift;
        @(posedge clk) disable iff (!rstn)
        !(cs_low && sclk_rise) |=> $stable(shift_r);
    endproperty
    a_hold_shift: assert property (p_hold_shift) else $error("shift moved"); // see R1

    property p_load;
        @(posedge clk) disable iff (!rstn)
        cs_rise |=> wiper_r == $past(shift_r);
    endproperty
    a_load: assert property (p_load) else $error("wiper not loaded"); // see R3

    property p_load_nobits;
        @(posedge clk) disable iff (!rstn)
        (cs_rise && shift_r == '0) |=> wiper_r == '0;
    endproperty
    a_load_nobits: assert property (p_load_nobits) else $error("zero load"); // see R9

    property p_no_change;
        @(posedge clk) disable iff (!rstn)
        !cs_rise |=> $stable(wiper_r);
    endproperty
    a_no_change: assert property (p_no_change) else $error("wiper moved"); // see R11

    property p_every_rise;
        @(posedge clk) disable iff (!rstn)
        cs_rise ##0 $stable(shift_r) |=> wiper_r == shift_r;
    endproperty
    a_every_rise: assert property (p_every_rise) else $error("rise skipped"); // see R4

    property p_decode;
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> tap_sel == decode($past(wiper_r));
    endproperty
    a_decode: assert property (p_decode) else $error("tap decode"); // see R10

    property p_midscale_hold;
        @(posedge clk) disable iff (!rstn)
        (wiper_r == CODE_W'(wiper_pkg::WIPER_RESET) && !cs_rise)
            |=> wiper_r == CODE_W'(wiper_pkg::WIPER_RESET);
    endproperty
    a_midscale_hold: assert property (p_midscale_hold) else $error("midscale lost"); // see R8

    property p_onehot;
        @(posedge clk) disable iff (!rstn)
        $onehot(tap_sel);
    endproperty
    a_onehot: assert property (p_onehot) else $error("tap not one-hot"); // see R10

    // Bit-level checks on the shift path, wiper hold, tap decode and pin events
    property p_shift_drop;
        @(posedge clk) disable iff (!rstn)
        (cs_low && sclk_rise) |=> shift_r[CODE_W-1:1] == $past(shift_r[CODE_W-2:0]);
    endproperty
    a_shift_drop: assert property (p_shift_drop) else $error("oldest bit kept"); // see R5

    property p_newest_bit;
        @(posedge clk) disable iff (!rstn)
        (cs_low && sclk_rise) |=> shift_r[0] == $past(sdi_s);
    endproperty
    a_newest_bit: assert property (p_newest_bit) else $error("newest bit wrong"); // see R2

    property p_idle_shift;
        @(posedge clk) disable iff (!rstn)
        !cs_low |=> $stable(shift_r);
    endproperty
    a_idle_shift: assert property (p_idle_shift) else $error("shift while deselected"); // see R1

    property p_low_hold;
        @(posedge clk) disable iff (!rstn)
        cs_low |=> $stable(wiper_r);
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("wiper moved in frame"); // see R11

    property p_b_end;
        @(posedge clk) disable iff (!rstn)
        wiper_r == '0 |=> tap_sel[0];
    endproperty
    a_b_end: assert property (p_b_end) else $error("code zero not at B end"); // see R10

    property p_mid_tap;
        @(posedge clk) disable iff (!rstn)
        wiper_r == CODE_W'(wiper_pkg::WIPER_RESET) |=> tap_sel[TAPS/2];
    endproperty
    a_mid_tap: assert property (p_mid_tap) else $error("midscale tap wrong"); // see R7

    property p_one_load;
        @(posedge clk) disable iff (!rstn)
        cs_rise |=> !cs_rise;
    endproperty
    a_one_load: assert property (p_one_load) else $error("select rise repeated"); // see R3

    property p_one_shift;
        @(posedge clk) disable iff (!rstn)
        sclk_rise |=> !sclk_rise;
    endproperty
    a_one_shift: assert property (p_one_shift) else $error("clock rise repeated"); // see R1
endmodule : spi_wiper_position_loader

// file: wiper_pkg.sv
// Purpose: Shared constants for the serial wiper position loader
// Assumes: 20 MHz system clock samples the serial link pins
// Notes: Codes are 8-bit wiper tap selections
package wiper_pkg;
    localparam int CODE_W = 8;
    localparam int TAPS = 256;
    localparam logic [7:0] WIPER_RESET = 8'h80;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam int SYNC_STAGES = 2;
    // Reset level of the pin synchronisers; high never fakes a rising edge
    localparam logic [2:0] PIN_IDLE = 3'h7;
    localparam int SCLK_POS = 2;
    localparam int CS_POS = 1;
    localparam int SDI_POS = 0;
endpackage : wiper_pkg

// file: spi_master_model.sv
// Purpose: Serial master model driving select, link clock and data
// Assumes: Link clock period 400 ns, eight clk periods
// Notes: Link clock stands low between frames; data inverts when deselected
`timescale 1ns/1ps
module spi_master_model (
    input wire logic clk,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic xfer(input logic [15:0] d, input int n);
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            sdi <= d[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        sdi <= ~sdi;
        repeat (8) @(posedge clk);
    endtask : xfer
    // Link clock pulses with select high, which the block must ignore
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            sdi <= ~sdi;
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
    endtask : stray
endmodule : spi_master_model

// file: tb_spi_wiper_position_loader.sv
// Purpose: Self-checking bench for the serial wiper loader
// Assumes: Model master paces frames from clk
// Notes: Results read a fixed settle time after each select rise
`timescale 1ns/1ps
module tb_spi_wiper_position_loader;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sclk, cs_n, sdi;
    logic [7:0] wiper_code;
    logic [255:0] tap_sel;
    int error_cnt = 0;
    int checks_done = 0;
    initial forever #25 clk = ~clk;
    spi_master_model spi_master_model_inst (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
    spi_wiper_position_loader spi_wiper_position_loader_inst (.clk(clk), .rstn(rstn),
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .wiper_code(wiper_code), .tap_sel(tap_sel));
    task automatic chk(input string n, input logic [255:0] s, input logic [255:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %0h seen %0h", n, e, s);
        end
    endtask : chk
    task automatic load(input logic [15:0] d, input int n, input logic [7:0] e);
        spi_master_model_inst.xfer(d, n);
        chk("wiper", {248'h0, wiper_code}, {248'h0, e});
        chk("tap", tap_sel, 256'h1 << e);
    endtask : load
    task automatic power_up();
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (40) @(posedge clk);
        chk("wiper", {248'h0, wiper_code}, 256'h80);
        chk("tap", tap_sel, 256'h1 << 128);
    endtask : power_up
    task automatic empty_toggle();
        load(16'h0000, 0, 8'h00);
    endtask : empty_toggle
    task automatic full_word();
        load(16'h00A5, 8, 8'hA5);
    endtask : full_word
    task automatic long_word();
        load(16'h0F3C, 12, 8'h3C);
    endtask : long_word
    task automatic repeat_copy();
        load(16'h0000, 0, 8'h3C);
    endtask : repeat_copy
    task automatic stray_clocks();
        spi_master_model_inst.stray(8);
        load(16'h0000, 0, 8'h3C);
    endtask : stray_clocks
    task automatic short_word();
        load(16'h0005, 4, 8'hC5);
    endtask : short_word
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        @(posedge clk);
        power_up();
        empty_toggle();
        full_word();
        long_word();
        repeat_copy();
        stray_clocks();
        short_word();
        power_up();
        empty_toggle();
        end_of_test();
    end
endmodule : tb_spi_wiper_position_loader
